// file: core/pss_pkg.sv
// constants, register map and state encoding of the power sequencer supervisor
package pss_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_MON   = 8'h04;
   localparam logic [7:0] OFS_POR   = 8'h08;
   localparam logic [7:0] OFS_STAT  = 8'h0c;
   localparam logic [7:0] OFS_FAULT = 8'h10;
   localparam logic [7:0] OFS_WARN  = 8'h14;
   localparam logic [7:0] OFS_WMASK = 8'h18;
   // control and monitor field positions
   localparam int CTRL_SWDIS  = 0;
   localparam int CTRL_TGT    = 1;
   localparam int CTRL_FHI    = 3;
   localparam int CTRL_FSEL   = 4;
   localparam int CTRL_CLAMP  = 7;
   localparam int CTRL_HIB    = 8;
   localparam int CTRL_PBEN   = 9;
   localparam int CTRL_WAKE   = 10;
   localparam int CTRL_TFMASK = 13;
   localparam int MON_THR     = 4;
   // reset values
   localparam logic [13:0] CTRL_RST  = 14'h0000;
   localparam logic [5:0]  MON_RST   = 6'h00;
   localparam logic [15:0] POR_RST   = 16'h1388;
   localparam logic [1:0]  WMASK_RST = 2'h3;
   // target voltage and frequency mode codes
   localparam logic [1:0] TGT_15V    = 2'h0;
   localparam logic [1:0] TGT_9V     = 2'h1;
   localparam logic [1:0] TGT_12V    = 2'h2;
   localparam logic [1:0] FM_SAFE    = 2'h0;
   localparam logic [1:0] FM_DEFAULT = 2'h1;
   localparam logic [1:0] FM_CONFIG  = 2'h2;
   // timing
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          MS_CYCLES     = CLK_HZ / 1000;
   localparam logic [12:0] START_TIME_MS = 13'h0006;
   localparam logic [12:0] WAKE_BASE_MS  = 13'h007d;
   // synchronised input bit positions
   localparam int SY_UVLO = 0;
   localparam int SY_S4V  = 1;
   localparam int SY_PG   = 2;
   localparam int SY_CSHI = 6;
   localparam int SY_TFLT = 7;
   localparam int SY_TWRN = 8;
   localparam int SY_MLOW = 9;
   localparam int SY_BTN  = 10;
   localparam int SY_W    = 11;

   typedef enum logic [2:0] {
      ST_SAFE    = 3'b000,
      ST_DEFAULT = 3'b001,
      ST_REG_SYS = 3'b010,
      ST_REG_IO  = 3'b011,
      ST_REG_MS  = 3'b100,
      ST_POR     = 3'b101,
      ST_RUN     = 3'b110,
      ST_HIB     = 3'b111
   } pss_state_t;
endpackage : pss_pkg

// file: core/pss_power_sequencer.sv
// power sequencer and supervisor with apb register slave
//
// Behaviour
// - switching target defaults to 15 V at start-up, 9 V or 12 V selectable later
// - high- or low-side sense mode decided from the sense pin and latched at start-up
// - safe start-up at 9.5 kHz until main supply clears its 4.3 V lockout
// - default 45 kHz for at least 6 ms before linear regulators are enabled
// - frequency setting offers high range 181-500 kHz and low range 45-125 kHz
// - above 4 V system supply, io, mixed-signal and core regulators start in turn
// - microcontroller leaves reset only with all four rails good and interval elapsed
// - hibernate entered by firmware request or push button, all supplies shut down
// - hibernate ends on wake timer, 125 ms to 8 s or never, or push button
// - leaving hibernate reruns start-up and resets the microcontroller
// - only persistent fault status survives hibernate, other state is lost
// - any rail below power good flags a fault and holds microcontroller reset
// - unmasked 170 C temperature fault resets the microcontroller
// - fault status bits survive the reset they cause
// - eight-way monitor select toward the converter pre-multiplexer
// - main supply low at 77 percent raises a maskable interrupt
// - 140 C temperature warning raises a maskable interrupt
// - four-level threshold reference select: 0.1, 0.2, 0.5, 1.25 V
`timescale 1ns/10ps
`default_nettype none
module pss_power_sequencer #(
   parameter int MS_CYC = pss_pkg::MS_CYCLES
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // analog comparators and pins
   input  wire logic        main_supply_ok,
   input  wire logic        system_supply_above_4v,
   input  wire logic [3:0]  rail_good,
   input  wire logic        current_sense_pin_high,
   input  wire logic        temp_fault,
   input  wire logic        temp_warn,
   input  wire logic        main_supply_low,
   input  wire logic        push_button_input,
   // switching supply control
   output logic             sw_enable,
   output logic      [1:0]  sw_freq_mode,
   output logic             sw_freq_hi,
   output logic      [2:0]  sw_freq_sel,
   output logic      [1:0]  sw_target,
   output logic             sw_clamp_en,
   output logic             hs_sense_mode,
   // regulators and reset
   output logic             sys_reg_en,
   output logic             io_reg_en,
   output logic             ms_reg_en,
   output logic             core_reg_en,
   output logic             mcu_reset_n,
   // monitor, reference, warning
   output logic      [2:0]  monitor_sel,
   output logic      [1:0]  threshold_sel,
   output logic             warn_irq
);
   import pss_pkg::*;

   logic [SY_W-1:0] sy1_q, sy_q;
   logic            pb_prev_q;
   pss_state_t      state_q, state_d;
   logic [15:0]     tick_q, tick_d;
   logic [12:0]     ms_q, ms_d;
   logic [15:0]     por_q, por_d;
   logic            hs_q, hs_d;
   logic [1:0]      fault_set;
   logic [13:0]     ctrl_q, ctrl_d;
   logic [5:0]      mon_q, mon_d;
   logic [15:0]     porcfg_q, porcfg_d;
   logic [1:0]      fault_q, fault_d, warn_q, warn_d, wmask_q, wmask_d;
   logic [31:0]     prdata_q, prdata_d;
   logic            pready_q, pready_d, pslverr_q, pslverr_d;
   logic [10:0]     out_q, out_d;
   logic            irq_q, irq_d;
   logic            wr, ms_tick, pb_rise, all_good, wake_hit;
   logic [12:0]     wake_lim;

   // analog comparator outputs are asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q     <= '0;
         sy_q      <= '0;
         pb_prev_q <= 1'b0;
      end else if (ce) begin
         sy1_q     <= {push_button_input, main_supply_low, temp_warn, temp_fault,
                       current_sense_pin_high, rail_good, system_supply_above_4v,
                       main_supply_ok};
         sy_q      <= sy1_q;
         pb_prev_q <= sy_q[SY_BTN];
      end
   end

   assign wr       = psel & penable & pready_q & pwrite;
   assign pb_rise  = sy_q[SY_BTN] & ~pb_prev_q;
   assign all_good = &sy_q[SY_PG +: 4];
   assign ms_tick  = (tick_q == 16'(MS_CYC - 1));
   // wake limit doubles per step: 125 ms at code 1 up to 8 s at code 7, 0 never wakes
   assign wake_lim = WAKE_BASE_MS << (ctrl_q[CTRL_WAKE +: 3] - 3'h1);
   assign wake_hit = (ctrl_q[CTRL_WAKE +: 3] != 3'h0) && (ms_q >= wake_lim);

   // sequencer
   always_comb begin
      state_d   = state_q;
      tick_d    = ms_tick ? 16'h0000 : tick_q + 16'h0001;
      ms_d      = (ms_tick && ms_q != 13'h1fff) ? ms_q + 13'h0001 : ms_q;
      por_d     = por_q;
      hs_d      = hs_q;
      fault_set = 2'b00;
      case (state_q)
         ST_SAFE: begin
            ms_d   = 13'h0000;
            tick_d = 16'h0000;
            if (sy_q[SY_UVLO]) begin
               hs_d    = sy_q[SY_CSHI];
               state_d = ST_DEFAULT;
            end
         end
         ST_DEFAULT: begin
            if (ms_q >= START_TIME_MS) state_d = ST_REG_SYS;
         end
         ST_REG_SYS: begin
            if (sy_q[SY_S4V]) state_d = ST_REG_IO;
         end
         ST_REG_IO: begin
            if (sy_q[SY_PG + 1]) state_d = ST_REG_MS;
         end
         ST_REG_MS: begin
            por_d = 16'h0000;
            if (sy_q[SY_PG + 2]) state_d = ST_POR;
         end
         ST_POR: begin
            if (!all_good) por_d = 16'h0000;
            else if (por_q >= porcfg_q) state_d = ST_RUN;
            else por_d = por_q + 16'h0001;
         end
         ST_RUN: begin
            por_d = 16'h0000;
            if (!all_good) begin
               fault_set[0] = 1'b1;
               state_d      = ST_POR;
            end else if (sy_q[SY_TFLT] && !ctrl_q[CTRL_TFMASK]) begin
               fault_set[1] = 1'b1;
               state_d      = ST_POR;
            end else if ((wr && paddr == OFS_CTRL && pwdata[CTRL_HIB]) ||
                         (ctrl_q[CTRL_PBEN] && pb_rise)) begin
               state_d = ST_HIB;
               ms_d    = 13'h0000;
               tick_d  = 16'h0000;
            end
         end
         ST_HIB: begin
            if (wake_hit || (ctrl_q[CTRL_PBEN] && pb_rise))
               state_d = ST_SAFE;
         end
         default: state_d = ST_SAFE;
      endcase
      // out: sw_en, fm[2], sys, io, ms, core, rst_n, spare[3]
      out_d[10]  = (state_d != ST_HIB) && !ctrl_q[CTRL_SWDIS];
      out_d[9:8] = (state_d == ST_SAFE) ? FM_SAFE :
                   (state_d == ST_RUN)  ? FM_CONFIG : FM_DEFAULT;
      out_d[7]   = (state_d >= ST_REG_SYS) && (state_d != ST_HIB);
      out_d[6]   = (state_d >= ST_REG_IO) && (state_d != ST_HIB);
      out_d[5]   = (state_d >= ST_REG_MS) && (state_d != ST_HIB);
      out_d[4]   = (state_d >= ST_POR) && (state_d != ST_HIB);
      out_d[3]   = (state_d == ST_RUN);
      out_d[2:0] = 3'h0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_SAFE;
         tick_q  <= 16'h0000;
         ms_q    <= 13'h0000;
         por_q   <= 16'h0000;
         hs_q    <= 1'b0;
         out_q   <= 11'h000;
      end else if (ce) begin
         state_q <= state_d;
         tick_q  <= tick_d;
         ms_q    <= ms_d;
         por_q   <= por_d;
         hs_q    <= hs_d;
         out_q   <= out_d;
      end
   end

   // register file
   always_comb begin
      ctrl_d    = ctrl_q;
      mon_d     = mon_q;
      porcfg_d  = porcfg_q;
      wmask_d   = wmask_q;
      pready_d  = 1'b0;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      ctrl_d[CTRL_HIB] = 1'b0;
      // set wins over a same-cycle write-one-to-clear
      fault_d = fault_q & ~((wr && paddr == OFS_FAULT) ? pwdata[1:0] : 2'b00);
      fault_d = fault_d | fault_set;
      warn_d  = warn_q & ~((wr && paddr == OFS_WARN) ? pwdata[1:0] : 2'b00);
      warn_d  = warn_d | {sy_q[SY_TWRN], sy_q[SY_MLOW]};
      if (wr) begin
         case (paddr)
            OFS_CTRL:  ctrl_d   = pwdata[13:0];
            OFS_MON:   mon_d    = pwdata[5:0];
            OFS_POR:   porcfg_d = pwdata[15:0];
            OFS_WMASK: wmask_d  = pwdata[1:0];
            default:   ;
         endcase
         ctrl_d[CTRL_HIB] = 1'b0;
      end
      if (psel && !penable) begin
         pready_d = 1'b1;
         case (paddr)
            OFS_CTRL:  prdata_d = {18'h00000, ctrl_q};
            OFS_MON:   prdata_d = {26'h0000000, mon_q};
            OFS_POR:   prdata_d = {16'h0000, porcfg_q};
            OFS_STAT:  prdata_d = {17'h00000, sy_q, hs_q, state_q};
            OFS_FAULT: prdata_d = {30'h00000000, fault_q};
            OFS_WARN:  prdata_d = {30'h00000000, warn_q};
            OFS_WMASK: prdata_d = {30'h00000000, wmask_q};
            default: begin
               prdata_d  = 32'h00000000;
               pslverr_d = 1'b1;
            end
         endcase
      end
      // all but the fault record is lost across hibernate
      if (state_q == ST_HIB && state_d != ST_HIB) begin
         ctrl_d   = CTRL_RST;
         mon_d    = MON_RST;
         porcfg_d = POR_RST;
         wmask_d  = WMASK_RST;
         warn_d   = 2'b00;
      end
      irq_d = |(warn_d & ~wmask_d);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= CTRL_RST;
         mon_q     <= MON_RST;
         porcfg_q  <= POR_RST;
         fault_q   <= 2'b00;
         warn_q    <= 2'b00;
         wmask_q   <= WMASK_RST;
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end else if (ce) begin
         ctrl_q    <= ctrl_d;
         mon_q     <= mon_d;
         porcfg_q  <= porcfg_d;
         fault_q   <= fault_d;
         warn_q    <= warn_d;
         wmask_q   <= wmask_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q     <= irq_d;
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign sw_enable     = out_q[10];
   assign sw_freq_mode  = out_q[9:8];
   assign sys_reg_en    = out_q[7];
   assign io_reg_en     = out_q[6];
   assign ms_reg_en     = out_q[5];
   assign core_reg_en   = out_q[4];
   assign mcu_reset_n   = out_q[3];
   assign sw_freq_hi    = ctrl_q[CTRL_FHI];
   assign sw_freq_sel   = ctrl_q[CTRL_FSEL +: 3];
   assign sw_target     = ctrl_q[CTRL_TGT +: 2];
   assign sw_clamp_en   = ctrl_q[CTRL_CLAMP];
   assign hs_sense_mode = hs_q;
   assign monitor_sel   = mon_q[2:0];
   assign threshold_sel = mon_q[MON_THR +: 2];
   assign warn_irq      = irq_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_hib_leave;
      (state_q == ST_HIB) ##1 (state_q != ST_HIB);
   endsequence
   sequence s_safe_leave;
      (state_q == ST_SAFE) ##1 (state_q == ST_DEFAULT);
   endsequence

   a_target_default: assert property ((state_q == ST_SAFE) |-> sw_target == TGT_15V)
      else $error("target not 15 V in safe start-up");
   a_mode_latch: assert property (s_safe_leave |-> hs_q == $past(sy_q[SY_CSHI]))
      else $error("sense mode not latched from pin");
   a_safe_hold: assert property (ce && state_q == ST_SAFE && !sy_q[SY_UVLO]
      |=> state_q == ST_SAFE && sw_freq_mode == FM_SAFE)
      else $error("left safe start-up without lockout clear");
   a_startup_min: assert property ((state_q == ST_DEFAULT && ms_q < START_TIME_MS)
      |=> !sys_reg_en)
      else $error("regulators enabled before 6 ms");
   a_reg_order: assert property ($rose(core_reg_en) |-> ms_reg_en && io_reg_en && sys_reg_en)
      else $error("regulators out of order");
   a_release_good: assert property ($rose(mcu_reset_n) |-> $past(all_good, 1))
      else $error("reset released without all rails good");
   a_hib_off: assert property ((state_q == ST_HIB) |-> !sw_enable && !sys_reg_en
      && !core_reg_en && !mcu_reset_n)
      else $error("supplies on in hibernate");
   a_hib_exit: assert property (s_hib_leave |-> state_q == ST_SAFE && !mcu_reset_n
      && ctrl_q == CTRL_RST)
      else $error("hibernate exit did not restart");
   a_rail_reset: assert property (ce && mcu_reset_n && !all_good
      |=> !mcu_reset_n && fault_q[0])
      else $error("rail loss did not reset");
   a_temp_reset: assert property (ce && state_q == ST_RUN && all_good && sy_q[SY_TFLT]
      && !ctrl_q[CTRL_TFMASK] |=> !mcu_reset_n && fault_q[1])
      else $error("temperature fault did not reset");
   a_fault_keep: assert property (ce && fault_q[0] && !(wr && paddr == OFS_FAULT)
      |=> fault_q[0])
      else $error("fault bit lost");
   a_warn_keep: assert property (ce && sy_q[SY_MLOW] && state_q != ST_HIB |=> warn_q[0])
      else $error("warning flag not set");
endmodule : pss_power_sequencer
`default_nettype wire

// file: verification/power_sequencer_supervisor_bench.sv
// self-checking bench for the power sequencer supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module power_sequencer_supervisor_bench;
   import pss_pkg::*;
   localparam int MS = 20;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [11:0] pins;} pss_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr;
   logic        main_supply_ok, system_supply_above_4v, sw_enable, hs_sense_mode;
   logic [3:0]  rail_good, en;
   logic [3:0]  en_q = 4'h0;
   logic        current_sense_pin_high = 1'b1;
   logic        temp_fault = 1'b0;
   logic        temp_warn = 1'b0;
   logic        main_supply_low = 1'b0;
   logic        push_button_input = 1'b0;
   logic        rail_drop = 1'b0;
   logic [1:0]  sw_freq_mode, sw_target, threshold_sel;
   logic [2:0]  sw_freq_sel, monitor_sel;
   logic        sw_freq_hi, sw_clamp_en, warn_irq, mcu_reset_n;
   logic        sys_reg_en, io_reg_en, ms_reg_en, core_reg_en;
   logic [11:0] pins;
   int          n_fail = 0;
   int          n_checks = 0;
   int          k;
   pss_row_t    rows [19] = '{
      '{1'b0, OFS_CTRL, 32'h0, 12'h000}, '{1'b0, OFS_MON, 32'h0, 12'h000},
      '{1'b0, OFS_POR, 32'h1388, 12'h000}, '{1'b0, OFS_FAULT, 32'h0, 12'h000},
      '{1'b0, OFS_WARN, 32'h0, 12'h000}, '{1'b0, OFS_WMASK, 32'h3, 12'h000},
      '{1'b1, OFS_CTRL, 32'h02, 12'h040}, '{1'b1, OFS_CTRL, 32'h04, 12'h080},
      '{1'b1, OFS_CTRL, 32'h78, 12'hf00}, '{1'b1, OFS_CTRL, 32'h80, 12'h020},
      '{1'b1, OFS_CTRL, 32'h00, 12'h000}, '{1'b1, OFS_MON, 32'h00, 12'h000},
      '{1'b1, OFS_MON, 32'h11, 12'h005}, '{1'b1, OFS_MON, 32'h22, 12'h00a},
      '{1'b1, OFS_MON, 32'h33, 12'h00f}, '{1'b1, OFS_MON, 32'h04, 12'h010},
      '{1'b1, OFS_MON, 32'h15, 12'h015}, '{1'b1, OFS_MON, 32'h26, 12'h01a},
      '{1'b1, OFS_MON, 32'h37, 12'h01f}};

   assign en   = {core_reg_en, ms_reg_en, io_reg_en, sys_reg_en};
   assign pins = {sw_freq_hi, sw_freq_sel, sw_target, sw_clamp_en, monitor_sel, threshold_sel};

   pss_power_sequencer #(.MS_CYC(MS)) uut (
      .pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .main_supply_ok(main_supply_ok), .system_supply_above_4v(system_supply_above_4v),
      .rail_good(rail_good), .current_sense_pin_high(current_sense_pin_high),
      .temp_fault(temp_fault), .temp_warn(temp_warn), .main_supply_low(main_supply_low),
      .push_button_input(push_button_input), .sw_enable(sw_enable),
      .sw_freq_mode(sw_freq_mode), .sw_freq_hi(sw_freq_hi), .sw_freq_sel(sw_freq_sel),
      .sw_target(sw_target), .sw_clamp_en(sw_clamp_en), .hs_sense_mode(hs_sense_mode),
      .sys_reg_en(sys_reg_en), .io_reg_en(io_reg_en), .ms_reg_en(ms_reg_en),
      .core_reg_en(core_reg_en), .mcu_reset_n(mcu_reset_n), .monitor_sel(monitor_sel),
      .threshold_sel(threshold_sel), .warn_irq(warn_irq)
   );

   pss_rail_model model (
      .pclk(pclk), .presetn(presetn), .sw_enable(sw_enable), .reg_en(en),
      .rail_drop(rail_drop), .main_supply_ok(main_supply_ok),
      .system_supply_above_4v(system_supply_above_4v), .rail_good(rail_good)
   );

   always #10 pclk = ~pclk;

   // regulators must come up one at a time and strictly in order
   always @(posedge pclk) begin
      en_q <= en;
      if (presetn && ($countones(en & ~en_q) > 1 || (en & ~{en[2:0], 1'b1}) != 4'h0)) begin
         n_fail++;
         $display("wrong value at %0t: regulator order %b", $time, en);
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count assumed: only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, exp)
   endtask : rd

   // reset release only after all rails good plus the full interval
   // pre: reset cycles already spent with all rails good before the call
   task automatic wait_run(input int pre = 0);
      int j;
      for (j = 0; j < 20000 && rail_good !== 4'hf; j++)
         @(posedge pclk);
      for (j = 0; j < 20000 && mcu_reset_n !== 1'b1; j++)
         @(posedge pclk);
      `CHK(j + pre >= int'(POR_RST) && rail_good === 4'hf && mcu_reset_n === 1'b1, 1'b1)
   endtask : wait_run

   task automatic press;
      push_button_input <= 1'b1;
      repeat (4) @(posedge pclk);
      push_button_input <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : press

   initial begin
      repeat (90000) @(posedge pclk);
      n_fail++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK({sw_enable, sw_freq_mode, mcu_reset_n, sys_reg_en}, {1'b1, FM_SAFE, 2'b00})
      for (k = 0; k < 200 && sw_freq_mode !== FM_DEFAULT; k++)
         @(posedge pclk);
      for (k = 0; k < 2000 && sys_reg_en !== 1'b1; k++)
         @(posedge pclk);
      `CHK(k >= 6 * MS && sys_reg_en === 1'b1, 1'b1)
      wait_run();
      `CHK(hs_sense_mode, 1'b1)
      `CHK(sw_freq_mode, FM_CONFIG)
      rd(OFS_STAT, 32'h000007fe);
      current_sense_pin_high <= 1'b0;
      $display("done: power-up");
      foreach (rows[i]) begin
         if (rows[i].wr)
            apb(1'b1, rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].d);
         `CHK(pins, rows[i].pins)
      end
      $display("done: register rows");
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      `CHK({sw_enable, hs_sense_mode}, 2'b01)
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      $display("done: disable and unmapped");
      rail_drop <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK(mcu_reset_n, 1'b0)
      rail_drop <= 1'b0;
      wait_run();
      rd(OFS_FAULT, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h2000);
      temp_fault <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK(mcu_reset_n, 1'b1)
      apb(1'b1, OFS_CTRL, 32'h0);
      repeat (8) @(posedge pclk);
      `CHK(mcu_reset_n, 1'b0)
      temp_fault <= 1'b0;
      wait_run(8);
      rd(OFS_FAULT, 32'h3);
      $display("done: faults");
      apb(1'b1, OFS_WMASK, 32'h2);
      temp_warn <= 1'b1;
      repeat (4) @(posedge pclk);
      temp_warn <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(warn_irq, 1'b0)
      rd(OFS_WARN, 32'h2);
      apb(1'b1, OFS_WMASK, 32'h0);
      repeat (3) @(posedge pclk);
      `CHK(warn_irq, 1'b1)
      apb(1'b1, OFS_WARN, 32'h2);
      repeat (3) @(posedge pclk);
      `CHK(warn_irq, 1'b0)
      main_supply_low <= 1'b1;
      repeat (4) @(posedge pclk);
      main_supply_low <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(warn_irq, 1'b1)
      rd(OFS_WARN, 32'h1);
      $display("done: warnings");
      apb(1'b1, OFS_CTRL, 32'h500);
      for (k = 0; k < 20 && sys_reg_en !== 1'b0; k++)
         @(posedge pclk);
      repeat (2) @(posedge pclk);
      `CHK({sw_enable, en, mcu_reset_n}, 6'h00)
      for (k = 0; k < 4000 && sw_enable !== 1'b1; k++)
         @(posedge pclk);
      `CHK(k > 125 * MS - 50 && k < 125 * MS + 50, 1'b1)
      `CHK(sw_freq_mode, FM_SAFE)
      wait_run();
      `CHK(hs_sense_mode, 1'b0)
      rd(OFS_FAULT, 32'h3);
      rd(OFS_WARN, 32'h0);
      rd(OFS_WMASK, 32'h3);
      apb(1'b1, OFS_FAULT, 32'h3);
      rd(OFS_FAULT, 32'h0);
      $display("done: timed hibernate");
      apb(1'b1, OFS_CTRL, 32'h200);
      press();
      for (k = 0; k < 20 && sw_enable !== 1'b0; k++)
         @(posedge pclk);
      `CHK(sw_enable, 1'b0)
      repeat (3000) @(posedge pclk);
      `CHK(sw_enable, 1'b0)
      press();
      for (k = 0; k < 20 && sw_enable !== 1'b1; k++)
         @(posedge pclk);
      `CHK(sw_enable, 1'b1)
      wait_run();
      $display("done: button hibernate");
      summarize();
   end
endmodule : power_sequencer_supervisor_bench
`default_nettype wire

// file: verification/pss_rail_model.sv
// supply and rail model for the analog side of the power sequencer
`timescale 1ns/10ps
`default_nettype none
module pss_rail_model #(
   parameter int MAIN_RISE = 40
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // enables from the sequencer
   input  wire logic       sw_enable,
   input  wire logic [3:0] reg_en,
   // fault injection from the bench
   input  wire logic       rail_drop,
   // comparator outputs
   output logic            main_supply_ok,
   output logic            system_supply_above_4v,
   output logic      [3:0] rail_good
);
   int unsigned main_cnt_q;
   logic [3:0]  good_q;
   // main supply collapses only when everything is off, as in hibernate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_cnt_q <= 0;
         good_q     <= 4'h0;
      end else begin
         if (!sw_enable && reg_en == 4'h0)
            main_cnt_q <= 0;
         else if (sw_enable && main_cnt_q < MAIN_RISE)
            main_cnt_q <= main_cnt_q + 1;
         good_q <= reg_en;
      end
   end
   assign main_supply_ok         = (main_cnt_q >= MAIN_RISE);
   assign system_supply_above_4v = good_q[0];
   assign rail_good              = good_q & {1'b1, ~rail_drop, 2'b11};
endmodule : pss_rail_model
`default_nettype wire
